// ### logic/audio_timer_pin_assign.sv
// Pin assignment for the audio serial port and the two 16-bit timers,
// with its three select registers on APB.
// Assumes a GPIO block supplies default pin drive and the pads return pin levels.
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pin_assign_defines.svh"
module audio_timer_pin_assign
	import pin_assign_pkg::*;
#(
	parameter int ADDR_W   = 12,
	parameter int NUM_PINS = 64
)(
	input  wire logic                pclk,
	input  wire logic                presetn,
	// APB slave
	input  wire logic [ADDR_W-1:0]   paddr,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [31:0]         pwdata,
	input  wire logic [3:0]          pstrb,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	// Pads and general-purpose defaults
	input  wire logic [NUM_PINS-1:0] pin_in,
	input  wire logic [NUM_PINS-1:0] gpio_out,
	input  wire logic [NUM_PINS-1:0] gpio_oe,
	output logic      [NUM_PINS-1:0] pin_out,
	output logic      [NUM_PINS-1:0] pin_oe,
	output logic      [NUM_PINS-1:0] pin_func_active,
	// Audio serial port
	output logic                     audio_serial_in,
	input  wire logic                audio_serial_output,
	input  wire logic                audio_word_select_out,
	input  wire logic                audio_word_select_oe,
	output logic                     audio_word_select_in,
	input  wire logic                audio_bit_clock_out,
	input  wire logic                audio_bit_clock_oe,
	output logic                     audio_bit_clock_in,
	input  wire logic                audio_master_clock_out,
	input  wire logic                audio_master_clock_oe,
	output logic                     audio_master_clock_in,
	// Timer A
	input  wire logic                timer_a_pulse_out_2,
	input  wire logic                timer_a_pulse_out_1,
	input  wire logic                timer_a_pulse_out_0,
	output logic                     timer_a_capture_in,
	// Timer B
	input  wire logic                timer_b_pulse_out_2,
	input  wire logic                timer_b_pulse_out_1,
	input  wire logic                timer_b_pulse_out_0,
	output logic                     timer_b_capture_in
);

	localparam int NF = `FUNC_COUNT;

	generate
		if (ADDR_W < 4 || NUM_PINS != `PIN_COUNT)
		begin : g_bad_params
			$error("audio_timer_pin_assign needs ADDR_W >= 4 and 64 pins");
		end
	endgenerate

	// Candidate pins per function, code 0 in the low entry, index order as func_* below
	localparam pin_table_t ROUTE_TABLE [NF] = '{
		{NO_PIN, NO_PIN, pin_at(2'd2, 4'd5), pin_at(2'd2, 4'd0),
			pin_at(2'd3, 4'd9), pin_at(2'd1, 4'd6), pin_at(2'd0, 4'd10), pin_at(2'd3, 4'd0)},
		{NO_PIN, NO_PIN, pin_at(2'd2, 4'd12), pin_at(2'd2, 4'd8),
			pin_at(2'd3, 4'd8), pin_at(2'd1, 4'd7), pin_at(2'd0, 4'd11), pin_at(2'd3, 4'd1)},
		{NO_PIN, NO_PIN, pin_at(2'd2, 4'd9), pin_at(2'd2, 4'd7),
			pin_at(2'd2, 4'd1), pin_at(2'd1, 4'd10), pin_at(2'd0, 4'd14), pin_at(2'd3, 4'd4)},
		{NO_PIN, NO_PIN, pin_at(2'd2, 4'd11), NO_PIN,
			NO_PIN, pin_at(2'd1, 4'd9), pin_at(2'd0, 4'd13), pin_at(2'd3, 4'd3)},
		{NO_PIN, NO_PIN, pin_at(2'd2, 4'd6), pin_at(2'd2, 4'd2),
			pin_at(2'd3, 4'd7), pin_at(2'd1, 4'd8), pin_at(2'd0, 4'd12), pin_at(2'd3, 4'd2)},
		{pin_at(2'd2, 4'd10), pin_at(2'd2, 4'd4), pin_at(2'd3, 4'd15), pin_at(2'd3, 4'd6),
			pin_at(2'd1, 4'd6), pin_at(2'd0, 4'd11), pin_at(2'd0, 4'd9), pin_at(2'd1, 4'd12)},
		{pin_at(2'd2, 4'd11), pin_at(2'd2, 4'd2), pin_at(2'd3, 4'd12), pin_at(2'd3, 4'd4),
			pin_at(2'd1, 4'd13), pin_at(2'd0, 4'd10), pin_at(2'd0, 4'd4), pin_at(2'd0, 4'd1)},
		{pin_at(2'd2, 4'd15), pin_at(2'd2, 4'd3), pin_at(2'd3, 4'd11), pin_at(2'd3, 4'd3),
			pin_at(2'd1, 4'd12), pin_at(2'd1, 4'd8), pin_at(2'd1, 4'd1), pin_at(2'd0, 4'd0)},
		{pin_at(2'd2, 4'd13), pin_at(2'd2, 4'd0), pin_at(2'd3, 4'd10), pin_at(2'd3, 4'd2),
			pin_at(2'd3, 4'd0), pin_at(2'd1, 4'd0), pin_at(2'd0, 4'd8), pin_at(2'd0, 4'd2)},
		{pin_at(2'd2, 4'd7), pin_at(2'd2, 4'd3), pin_at(2'd3, 4'd8), pin_at(2'd1, 4'd14),
			pin_at(2'd1, 4'd2), pin_at(2'd0, 4'd15), pin_at(2'd0, 4'd6), pin_at(2'd1, 4'd9)},
		{pin_at(2'd2, 4'd8), pin_at(2'd2, 4'd4), pin_at(2'd3, 4'd9), pin_at(2'd1, 4'd10),
			pin_at(2'd1, 4'd3), pin_at(2'd0, 4'd12), pin_at(2'd0, 4'd8), pin_at(2'd0, 4'd11)},
		{pin_at(2'd2, 4'd12), pin_at(2'd2, 4'd0), pin_at(2'd3, 4'd14), pin_at(2'd3, 4'd7),
			pin_at(2'd1, 4'd15), pin_at(2'd1, 4'd9), pin_at(2'd0, 4'd5), pin_at(2'd0, 4'd10)},
		{NO_PIN, pin_at(2'd2, 4'd1), pin_at(2'd3, 4'd13), pin_at(2'd3, 4'd5),
			pin_at(2'd1, 4'd11), pin_at(2'd1, 4'd7), pin_at(2'd0, 4'd7), pin_at(2'd0, 4'd12)}
	};

	logic [31:0] audio_serial_pin_assign_reg;
	logic [31:0] audio_serial_pin_assign_next;
	logic [31:0] timer16_a_pin_assign_reg;
	logic [31:0] timer16_a_pin_assign_next;
	logic [31:0] timer16_b_pin_assign_reg;
	logic [31:0] timer16_b_pin_assign_next;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic [31:0] lane_mask;
	logic        hit_audio;
	logic        hit_timer_a;
	logic        hit_timer_b;
	logic        wr_access;

	pin_sel_t            func_sel  [NF];
	logic [NUM_PINS-1:0] func_mask [NF];
	logic [NF-1:0]       func_drv;
	logic [NF-1:0]       func_oe;
	logic [NF-1:0]       func_in;

	// Decode on the low address bits; the upper bits must be zero for a hit
	assign hit_audio   = (paddr == ADDR_W'(`AUDIO_PIN_ASSIGN_OFS));
	assign hit_timer_a = (paddr == ADDR_W'(`TIMER_A_PIN_ASSIGN_OFS));
	assign hit_timer_b = (paddr == ADDR_W'(`TIMER_B_PIN_ASSIGN_OFS));
	assign wr_access   = psel && penable && pwrite;
	assign lane_mask   = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

	// Zero-wait slave: the access phase always completes on its first edge
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !(hit_audio || hit_timer_a || hit_timer_b);
	assign prdata  = prdata_reg;

	// Register writes honour byte strobes; reserved bits are masked away
	always_comb
	begin
		audio_serial_pin_assign_next = audio_serial_pin_assign_reg;
		timer16_a_pin_assign_next    = timer16_a_pin_assign_reg;
		timer16_b_pin_assign_next    = timer16_b_pin_assign_reg;
		if (wr_access && hit_audio)
			audio_serial_pin_assign_next = ((audio_serial_pin_assign_reg & ~lane_mask) | (pwdata & lane_mask))
				& `AUDIO_PIN_ASSIGN_MASK; // [RULE14]
		if (wr_access && hit_timer_a)
			timer16_a_pin_assign_next = ((timer16_a_pin_assign_reg & ~lane_mask) | (pwdata & lane_mask))
				& `TIMER_PIN_ASSIGN_MASK; // [RULE14]
		if (wr_access && hit_timer_b)
			timer16_b_pin_assign_next = ((timer16_b_pin_assign_reg & ~lane_mask) | (pwdata & lane_mask))
				& `TIMER_PIN_ASSIGN_MASK; // [RULE14]
	end

	// Read data is captured in the setup cycle so it is steady through the access phase
	always_comb
	begin
		prdata_next = prdata_reg;
		if (psel && !penable && !pwrite)
		begin
			if (hit_audio)
				prdata_next = audio_serial_pin_assign_reg;
			else if (hit_timer_a)
				prdata_next = timer16_a_pin_assign_reg;
			else if (hit_timer_b)
				prdata_next = timer16_b_pin_assign_reg;
			else
				prdata_next = 32'h0000_0000;
		end
	end

	// Select registers; a new value steers the pins from the next edge on
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			audio_serial_pin_assign_reg <= `PIN_ASSIGN_RESET;
			timer16_a_pin_assign_reg    <= `PIN_ASSIGN_RESET;
			timer16_b_pin_assign_reg    <= `PIN_ASSIGN_RESET;
			prdata_reg                  <= 32'h0000_0000;
		end
		else
		begin
			audio_serial_pin_assign_reg <= audio_serial_pin_assign_next; // [RULE15]
			timer16_a_pin_assign_reg    <= timer16_a_pin_assign_next;    // [RULE15]
			timer16_b_pin_assign_reg    <= timer16_b_pin_assign_next;    // [RULE15]
			prdata_reg                  <= prdata_next;
		end
	end

	// Field extraction, in the same order as the route table
	always_comb
	begin
		func_sel[0]  = audio_serial_pin_assign_reg[`DIN_LSB +: `FIELD_W];  // [RULE1]
		func_sel[1]  = audio_serial_pin_assign_reg[`DOUT_LSB +: `FIELD_W]; // [RULE2]
		func_sel[2]  = audio_serial_pin_assign_reg[`WS_LSB +: `FIELD_W];   // [RULE3]
		func_sel[3]  = audio_serial_pin_assign_reg[`BCLK_LSB +: `FIELD_W]; // [RULE4]
		func_sel[4]  = audio_serial_pin_assign_reg[`MCLK_LSB +: `FIELD_W]; // [RULE5]
		func_sel[5]  = timer16_a_pin_assign_reg[`PULSE2_LSB +: `FIELD_W];  // [RULE6]
		func_sel[6]  = timer16_a_pin_assign_reg[`PULSE1_LSB +: `FIELD_W];  // [RULE7]
		func_sel[7]  = timer16_a_pin_assign_reg[`PULSE0_LSB +: `FIELD_W];  // [RULE8]
		func_sel[8]  = timer16_a_pin_assign_reg[`CAPTURE_LSB +: `FIELD_W]; // [RULE9]
		func_sel[9]  = timer16_b_pin_assign_reg[`PULSE2_LSB +: `FIELD_W];  // [RULE10]
		func_sel[10] = timer16_b_pin_assign_reg[`PULSE1_LSB +: `FIELD_W];  // [RULE11]
		func_sel[11] = timer16_b_pin_assign_reg[`PULSE0_LSB +: `FIELD_W];  // [RULE12]
		func_sel[12] = timer16_b_pin_assign_reg[`CAPTURE_LSB +: `FIELD_W]; // [RULE13]
	end

	// One decoder per field turns a code into a one-hot pin mask
	generate
		for (genvar f = 0; f < NF; f++)
		begin : g_field
			pin_field_decode #(
				.NUM_PINS  (NUM_PINS),
				.PIN_TABLE (ROUTE_TABLE[f])
			) u_decode (
				.sel      (func_sel[f]),
				.pin_mask (func_mask[f])
			);
		end
	endgenerate

	// Function-side drive; inputs only listen, timer pulses always drive
	always_comb
	begin
		func_drv = '0;
		func_oe  = '0;
		func_drv[1]  = audio_serial_output;
		func_oe[1]   = 1'b1;
		func_drv[2]  = audio_word_select_out;
		func_oe[2]   = audio_word_select_oe;
		func_drv[3]  = audio_bit_clock_out;
		func_oe[3]   = audio_bit_clock_oe;
		func_drv[4]  = audio_master_clock_out;
		func_oe[4]   = audio_master_clock_oe;
		func_drv[5]  = timer_a_pulse_out_2;
		func_drv[6]  = timer_a_pulse_out_1;
		func_drv[7]  = timer_a_pulse_out_0;
		func_drv[9]  = timer_b_pulse_out_2;
		func_drv[10] = timer_b_pulse_out_1;
		func_drv[11] = timer_b_pulse_out_0;
		func_oe[7:5]   = 3'b111;
		func_oe[11:9]  = 3'b111;
	end

	// Pin side: lowest function index wins a shared pin; unclaimed pins stay GPIO.
	// Sharing a pin is a software error, the fixed order only keeps it deterministic.
	always_comb
	begin
		pin_out         = gpio_out;
		pin_oe          = gpio_oe;
		pin_func_active = '0;
		for (int f = NF - 1; f >= 0; f--)
		begin
			for (int p = 0; p < NUM_PINS; p++)
			begin
				if (func_mask[f][p])
				begin
					pin_func_active[p] = 1'b1;        // [RULE15]
					pin_out[p]         = func_drv[f];
					pin_oe[p]          = func_oe[f];
				end
			end
		end
	end

	// Each function hears only its selected pin, and zero when none is selected
	always_comb
	begin
		for (int f = 0; f < NF; f++)
			func_in[f] = |(pin_in & func_mask[f]); // [RULE14]
	end

	assign audio_serial_in       = func_in[0]; // [RULE1]
	assign audio_word_select_in  = func_in[2]; // [RULE3]
	assign audio_bit_clock_in    = func_in[3]; // [RULE4]
	assign audio_master_clock_in = func_in[4]; // [RULE5]
	assign timer_a_capture_in    = func_in[8]; // [RULE9]
	assign timer_b_capture_in    = func_in[12]; // [RULE13]

endmodule
`default_nettype wire

// ### logic/pin_assign_defines.svh
// Constants for the peripheral pin assignment block: offsets, field positions,
// reset values and the register masks.
// Assumes 32-bit APB data and a flat 64-entry pin numbering of port*16+bit.
//
// Summary of operation
// [RULE1] Audio serial input is taken from the pin chosen by bits 19:16.
// [RULE2] Audio serial output drives the pin chosen by bits 15:12.
// [RULE3] Audio word select uses the pin chosen by bits 11:8.
// [RULE4] Audio bit clock uses the pin chosen by bits 7:4; unlisted codes stay unused.
// [RULE5] Audio master clock uses the pin chosen by bits 3:0.
// [RULE6] Timer A pulse output 2 goes to the pin chosen by bits 15:12.
// [RULE7] Timer A pulse output 1 goes to the pin chosen by bits 11:8.
// [RULE8] Timer A pulse output 0 goes to the pin chosen by bits 7:4.
// [RULE9] Timer A capture input comes from the pin chosen by bits 3:0.
// [RULE10] Timer B pulse output 2 goes to the pin chosen by bits 15:12.
// [RULE11] Timer B pulse output 1 goes to the pin chosen by bits 11:8.
// [RULE12] Timer B pulse output 0 goes to the pin chosen by bits 7:4.
// [RULE13] Timer B capture input comes from the pin chosen by bits 3:0.
// [RULE14] Unlisted codes connect nothing; upper reserved bits read zero, ignore writes.
// [RULE15] New select applies the edge after the write; other pins stay general purpose.
`ifndef PIN_ASSIGN_DEFINES_SVH
`define PIN_ASSIGN_DEFINES_SVH

`define AUDIO_PIN_ASSIGN_OFS   12'h000
`define TIMER_A_PIN_ASSIGN_OFS 12'h004
`define TIMER_B_PIN_ASSIGN_OFS 12'h008

`define AUDIO_PIN_ASSIGN_MASK  32'h000f_ffff
`define TIMER_PIN_ASSIGN_MASK  32'h0000_ffff
`define PIN_ASSIGN_RESET       32'h0000_0000

`define FIELD_W                4
`define DIN_LSB                16
`define DOUT_LSB               12
`define WS_LSB                 8
`define BCLK_LSB               4
`define MCLK_LSB               0
`define PULSE2_LSB             12
`define PULSE1_LSB             8
`define PULSE0_LSB             4
`define CAPTURE_LSB            0

`define CODE_COUNT             8
`define PIN_COUNT              64
`define FUNC_COUNT             13

`endif

// ### logic/pin_assign_pkg.sv
// Types shared by the pin assignment block and its field decoder.
// Assumes pins are numbered port*16+bit over four 16-bit ports.
package pin_assign_pkg;

	typedef logic [3:0] pin_sel_t;
	// Table entry: bit 6 marks a listed code, bits 5:0 the flat pin index
	typedef logic [6:0] pin_entry_t;
	typedef logic [55:0] pin_table_t;

	localparam pin_entry_t NO_PIN = 7'h00;

	function automatic pin_entry_t pin_at(input logic [1:0] port, input logic [3:0] bit_no);
		pin_at = {1'b1, port, bit_no};
	endfunction

endpackage

// ### logic/pin_field_decode.sv
// One select field to a one-hot mask of the pin it picks.
// Assumes the table holds eight 7-bit entries, code 0 in the low bits.
`timescale 1ns/1ps
`default_nettype none
module pin_field_decode
	import pin_assign_pkg::*;
#(
	parameter int         NUM_PINS  = 64,
	parameter pin_table_t PIN_TABLE = '0
)(
	input  wire logic [3:0]          sel,
	output logic      [NUM_PINS-1:0] pin_mask
);

	generate
		if (NUM_PINS != 64)
		begin : g_bad_pins
			$error("pin_field_decode serves exactly 64 pins");
		end
	endgenerate

	// Codes 8 and above and unlisted table entries select no pin at all
	always_comb
	begin
		pin_entry_t entry;
		entry = NO_PIN;
		pin_mask = '0;
		if (!sel[3])
			entry = PIN_TABLE[{sel[2:0], 3'b000} - {3'b000, sel[2:0]} +: 7];
		if (entry[6])
			pin_mask[entry[5:0]] = 1'b1; // [RULE14]
	end

endmodule
`default_nettype wire

// ### verification/pin_assign_checker.sv
// Concurrent checks on the pin assignment block, seen from its ports only.
// Assumes zero-wait APB with the three registers at 0x000, 0x004 and 0x008.
`timescale 1ns/1ps
`default_nettype none
module pin_assign_checker
#(
	parameter int ADDR_W   = 12,
	parameter int NUM_PINS = 64
)(
	input wire logic                pclk,
	input wire logic                presetn,
	input wire logic [ADDR_W-1:0]   paddr,
	input wire logic                psel,
	input wire logic                penable,
	input wire logic                pwrite,
	input wire logic [31:0]         pwdata,
	input wire logic [3:0]          pstrb,
	input wire logic [31:0]         prdata,
	input wire logic                pslverr,
	input wire logic [NUM_PINS-1:0] pin_in,
	input wire logic [NUM_PINS-1:0] gpio_out,
	input wire logic [NUM_PINS-1:0] gpio_oe,
	input wire logic [NUM_PINS-1:0] pin_out,
	input wire logic [NUM_PINS-1:0] pin_oe,
	input wire logic [NUM_PINS-1:0] pin_func_active,
	input wire logic                audio_serial_output,
	input wire logic                timer_a_capture_in,
	input wire logic                timer_b_capture_in
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Access phase of any transfer
	logic acc;
	assign acc = psel && penable;

	// Bus answers: error only on unmapped places, reserved bits read zero
	AST_SLVERR: assert property (acc |-> pslverr == !(paddr inside {'h0, 'h4, 'h8}))
		else $error("error response does not match the address");
	AST_NO_IDLE_ERR: assert property (!acc |-> !pslverr)
		else $error("error response outside an access phase");
	AST_RSVD_AUDIO: assert property (acc && !pwrite && paddr == 'h0 |-> prdata[31:20] == 12'h000)
		else $error("audio register upper bits not zero");
	AST_RSVD_TIMER: assert property (acc && !pwrite && paddr inside {'h4, 'h8} |-> prdata[31:16] == 16'h0000)
		else $error("timer register upper bits not zero");
	AST_UNMAPPED_RD: assert property (acc && !pwrite && pslverr |-> prdata == 32'h0)
		else $error("unmapped read returned data");

	// Unclaimed pins keep their general-purpose drive
	AST_GPIO_PASS: assert property ((((pin_out ^ gpio_out) | (pin_oe ^ gpio_oe)) & ~pin_func_active) == '0)
		else $error("unclaimed pin lost its general-purpose drive");
	// Right after reset the audio code-0 pins P3.0..P3.4 are claimed, output on P3.1
	AST_RESET_PINS: assert property ($rose(presetn) |-> pin_func_active[52:48] == 5'h1f && pin_oe[49] && !pin_oe[48])
		else $error("audio default pins not claimed after reset");

	// A new select is in force from the edge after the write
	AST_DOUT_APPLY: assert property (acc && pwrite && paddr == 'h0 && pstrb[1] && pwdata[15:12] == 4'h1
		|=> pin_oe[11] && pin_out[11] == audio_serial_output)
		else $error("serial output not on P0.11 after select write");
	AST_CAPA_APPLY: assert property (acc && pwrite && paddr == 'h4 && pstrb[0] && pwdata[3:0] == 4'h3
		|=> timer_a_capture_in == pin_in[48])
		else $error("timer A capture not taken from P3.0");
	AST_CAPB_NONE: assert property (acc && pwrite && paddr == 'h8 && pstrb[0] && pwdata[3:0] == 4'hf
		|=> !timer_b_capture_in)
		else $error("reserved capture code still connects a pin");

	COV_UNMAPPED: cover property (acc && pslverr);
	COV_TIMER_B_WRITE: cover property (acc && pwrite && paddr == 'h8);
	COV_RESET_RELEASE: cover property ($rose(presetn));
endmodule
`default_nettype wire

// ### verification/pad_model.sv
// Pad model: the general-purpose pins as seen from outside the chip.
// Assumes a driven pad reads back its own drive; an undriven pad follows pad_level.
`timescale 1ns/1ps
`default_nettype none
module pad_model
#(
	parameter int NUM_PINS = 64
)(
	input  wire logic [NUM_PINS-1:0] pin_out,
	input  wire logic [NUM_PINS-1:0] pin_oe,
	input  wire logic [NUM_PINS-1:0] pad_level,
	output logic      [NUM_PINS-1:0] pin_in
);
	// Released pads take the outside level, so a stale drive never reads back
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & pad_level);
endmodule
`default_nettype wire

// ### verification/audio_timer_pin_assign_tb.sv
// Self-checking bench for the audio and timer pin assignment block.
// Assumes zero-wait APB registers at 0x000, 0x004, 0x008 and the pad model beside it.
`timescale 1ns/1ps
`default_nettype none
module audio_timer_pin_assign_tb;
	// Flat pin index (port*16+bit) per field and code; 255 where a code selects no pin
	localparam byte unsigned PIN_TBL [13][8] = '{
		'{48, 10, 22, 57, 32, 37, 255, 255}, '{49, 11, 23, 56, 40, 44, 255, 255},
		'{52, 14, 26, 33, 39, 41, 255, 255}, '{51, 13, 25, 255, 255, 43, 255, 255},
		'{50, 12, 24, 55, 34, 38, 255, 255}, '{28, 9, 11, 22, 54, 63, 36, 42},
		'{1, 4, 10, 29, 52, 60, 34, 43}, '{0, 17, 24, 28, 51, 59, 35, 47},
		'{2, 8, 16, 48, 50, 58, 32, 45}, '{25, 6, 15, 18, 30, 56, 35, 39},
		'{11, 8, 12, 19, 26, 57, 36, 40}, '{10, 5, 25, 31, 55, 62, 32, 44},
		'{12, 7, 23, 27, 53, 61, 33, 255}};
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, fd, toe, er;
	logic        audio_serial_in, timer_a_capture_in, timer_b_capture_in, ws_in, bclk_in, mclk_in;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  pstrb;
	logic [63:0] pin_in, pin_out, pin_oe, pin_func_active, gpio_out, gpio_oe, pad_level;
	int          err_count, total_checks;

	audio_timer_pin_assign uut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .pin_in, .gpio_out, .gpio_oe, .pin_out, .pin_oe, .pin_func_active,
		.audio_serial_in, .audio_serial_output(fd), .audio_word_select_out(fd), .audio_word_select_oe(toe),
		.audio_word_select_in(ws_in), .audio_bit_clock_out(fd), .audio_bit_clock_oe(toe),
		.audio_bit_clock_in(bclk_in), .audio_master_clock_out(fd), .audio_master_clock_oe(toe),
		.audio_master_clock_in(mclk_in),
		.timer_a_pulse_out_2(fd), .timer_a_pulse_out_1(fd), .timer_a_pulse_out_0(fd), .timer_a_capture_in,
		.timer_b_pulse_out_2(fd), .timer_b_pulse_out_1(fd), .timer_b_pulse_out_0(fd), .timer_b_capture_in);
	pad_model pads (.pin_out, .pin_oe, .pad_level, .pin_in);

	// 200 MHz clock
	always #2.5 pclk = ~pclk;

	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic ok, input string what);
		total_checks++;
		if (ok !== 1'b1)
		begin
			err_count++;
			$display("mismatch at %0t: %s", $time, what);
		end
	endtask

	// One APB transfer; the request holds until pready is seen high at an edge
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= d;
		pstrb   <= s;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		chk(n < 20, "no ready from slave");
		if (n >= 20)
			end_sim();
		#1;
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
		apb(a, 1'b0, 32'h0, 4'h0);
		chk(rd === exp && er === exp_err, "register read back");
	endtask

	// After reset every field is code 0000 and claims its code-0 pin
	task automatic reset_chk;
		logic [63:0] m;
		m = '0;
		for (int f = 0; f < 13; f++)
			m[PIN_TBL[f][0]] = 1'b1;
		chk(pin_func_active === m, "code-0 pins not claimed");
		for (int r = 0; r < 3; r++)
			rd_chk(12'(4 * r), 32'h0, 1'b0);
	endtask

	// Walk one field through codes 0..8 with every other field parked on a reserved code
	task automatic field_chk(input int f);
		int          ra, sh;
		logic        inp, obuf;
		logic [31:0] wv, mk;
		logic [63:0] m;
		ra   = f < 5 ? 0 : (f < 9 ? 1 : 2);
		sh   = f < 5 ? 16 - 4 * f : 12 - 4 * ((f - 5) % 4);
		mk   = ra == 0 ? 32'h000f_ffff : 32'h0000_ffff;
		inp  = f == 0 || f == 8 || f == 12;
		obuf = !inp && f != 3;
		@(posedge pclk);
		fd  <= f % 2 == 0;
		toe <= f != 3;
		for (int r = 0; r < 3; r++)
			apb(12'(4 * r), 1'b1, 32'hffff_ffff, 4'hf);
		for (int c = 0; c < 9; c++)
		begin
			wv = ~(32'hf << sh) | (32'(c) << sh);
			apb(12'(4 * ra), 1'b1, wv, 4'hf);
			m = (c < 8 && PIN_TBL[f][c] != 255) ? 64'h1 << PIN_TBL[f][c] : 64'h0;
			chk(pin_func_active === m && pin_oe === (obuf ? m : 64'h0), "pin claim");
			chk(pin_out === (!inp && fd ? m : 64'h0), "pin drive level");
			if (inp)
				chk((f == 0 ? audio_serial_in : (f == 8 ? timer_a_capture_in : timer_b_capture_in)) === (m != 0),
					"function input level");
			// Two-way audio pins read back the pad, driven or pulled high
			if (f >= 2 && f <= 4)
				chk((f == 2 ? ws_in : (f == 3 ? bclk_in : mclk_in)) === (m != 0),
					"two-way function input level");
			rd_chk(12'(4 * ra), wv & mk, 1'b0);
		end
	endtask

	initial
	begin
		pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0; pstrb = '0;
		fd = 1; toe = 1; gpio_out = '0; gpio_oe = '0; pad_level = '1; err_count = 0; total_checks = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		reset_chk();
		for (int f = 0; f < 13; f++)
			field_chk(f);
		// Byte lanes, then the unmapped place: write ignored, read zero with error
		apb(12'h000, 1'b1, 32'h0, 4'b0010);
		rd_chk(12'h000, 32'h000f_00ff, 1'b0);
		apb(12'h00c, 1'b1, 32'h0, 4'hf);
		chk(er === 1'b1, "unmapped write accepted");
		rd_chk(12'h00c, 32'h0, 1'b1);
		rd_chk(12'h004, 32'h0000_ffff, 1'b0);
		// All fields reserved: every pin is back under general-purpose control
		apb(12'h000, 1'b1, 32'hffff_ffff, 4'hf);
		@(posedge pclk);
		gpio_out <= 64'h5a5a_0f0f_3c3c_a5a5;
		gpio_oe  <= 64'hf0f0_1234_8765_0ff0;
		@(posedge pclk);
		#1;
		chk(pin_out === 64'h5a5a_0f0f_3c3c_a5a5 && pin_oe === 64'hf0f0_1234_8765_0ff0 && pin_func_active === 64'h0,
			"general-purpose pass-through");
		// Reset in mid-run must bring every field back to code 0000
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		reset_chk();
		end_sim();
	end
endmodule

bind audio_timer_pin_assign pin_assign_checker #(.ADDR_W(ADDR_W), .NUM_PINS(NUM_PINS)) chk_i (
	.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pslverr, .pin_in,
	.gpio_out, .gpio_oe, .pin_out, .pin_oe, .pin_func_active, .audio_serial_output, .timer_a_capture_in,
	.timer_b_capture_in);
`default_nettype wire
